// >>> hw/ddc_device_disable.sv
`timescale 1ns/1ps
`include "ddc_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RL1: Driving the request pin low starts entry into disable mode.
// RL2: Request pin has pull-up; open pin reads idle, device runs normally.
// RL3: Disable allowed only when memory-loaded allow bit is set; default off.
// RL4: While disabled: link in L3, PHY powered down, outputs high impedance.
// RL5: While disabled, host link reset is ignored; stay disabled while asserted.
// RL6: After host reset release, may leave mode briefly; re-enter after memory reload.
// RL7: At power-up, pin ignored until memory read completes.
// RL8: Driver holds level through reset and sleep; defaults high at power-up.
// RL9: Firmware lets link come up after power good, then drives request low.
// RL10: Firmware may idle the far link end after disabling.
// RL11: Firmware re-enables by driving request high, then re-enumerates.
// RL12: Request passes a synchroniser before any state decision.
module ddc_device_disable (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_disable_request_n,
    input wire logic i_disable_request_n_oe,
    input wire logic i_host_link_reset_n,
    input wire logic i_nvm_load_done,
    input wire logic i_nvm_disable_allow,
    output logic o_device_disabled,
    output logic [1:0] o_link_state,
    output logic o_phy_power_down,
    output logic o_output_buffers_oe,
    output logic o_core_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin pull-up and synchroniser
    wire pin_level = i_disable_request_n_oe ? i_disable_request_n : `DDC_REQ_IDLE; // [RL2]
    ddc_sync_if sif ();
    assign sif.raw = pin_level;
    ddc_pin_sync u_sync ( // [RL12]
        .i_clk(i_clk),
        .i_rst(i_rst),
        .s(sif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Host reset synchroniser and release detect
    logic prst_lvl_q;
    logic allow_q;
    ddc_pkg::ddc_state_t state_q;
    ddc_pkg::ddc_state_t state_d;
    ddc_sync_if hif ();
    assign hif.raw = i_host_link_reset_n;
    ddc_pin_sync #(
        .RST_LEVEL(`DDC_HRST_RESET)
    ) u_host_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .s(hif)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prst_lvl_q <= `DDC_HRST_RESET;
        end else begin
            prst_lvl_q <= hif.level;
        end
    end

    wire prst_release = hif.level & ~prst_lvl_q;
    wire req_on = sif.level == `DDC_REQ_ASSERTED; // [RL1]
    wire may_disable = req_on & allow_q; // [RL3]

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ddc_pkg::DDC_ST_WAIT_NVM: begin
                if (i_nvm_load_done) begin // [RL7]
                    state_d = (i_nvm_disable_allow & req_on) ? ddc_pkg::DDC_ST_DISABLED : ddc_pkg::DDC_ST_ACTIVE;
                end
            end
            ddc_pkg::DDC_ST_ACTIVE: begin
                if (prst_release) begin // [RL6]
                    state_d = ddc_pkg::DDC_ST_WAIT_NVM;
                end else if (may_disable) begin
                    state_d = ddc_pkg::DDC_ST_DISABLED; // [RL1]
                end
            end
            ddc_pkg::DDC_ST_DISABLED: begin
                if (!req_on) begin // [RL5]
                    state_d = ddc_pkg::DDC_ST_WAIT_NVM;
                end else if (prst_release) begin // [RL6]
                    state_d = ddc_pkg::DDC_ST_WAIT_NVM;
                end
            end
            default: begin
                state_d = ddc_pkg::DDC_ST_WAIT_NVM;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ddc_pkg::DDC_ST_WAIT_NVM;
            allow_q <= `DDC_ALLOW_RESET;
        end else begin
            state_q <= state_d;
            if (state_q == ddc_pkg::DDC_ST_WAIT_NVM && i_nvm_load_done) begin
                allow_q <= i_nvm_disable_allow; // [RL3]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, registered from the next state
    wire dis_d = state_d == ddc_pkg::DDC_ST_DISABLED;
    wire wait_d = state_d == ddc_pkg::DDC_ST_WAIT_NVM;
    wire [1:0] link_d = dis_d ? `DDC_LINK_L3 : `DDC_LINK_L0; // [RL4]
    logic dis_q;
    logic [1:0] link_q;
    logic phy_pd_q;
    logic buf_oe_q;
    logic core_rst_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dis_q <= `DDC_FLAG_OFF;
            link_q <= `DDC_LINK_L0;
            phy_pd_q <= `DDC_FLAG_OFF;
            buf_oe_q <= `DDC_FLAG_ON;
            core_rst_q <= `DDC_FLAG_ON;
        end else begin
            dis_q <= dis_d;
            link_q <= link_d; // [RL4]
            phy_pd_q <= dis_d; // [RL4]
            buf_oe_q <= ~dis_d; // [RL4]
            core_rst_q <= wait_d;
        end
    end

    assign o_device_disabled = dis_q;
    assign o_link_state = link_q;
    assign o_phy_power_down = phy_pd_q;
    assign o_output_buffers_oe = buf_oe_q;
    assign o_core_reset = core_rst_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_wait_ignores_pin: assert property (@(posedge i_clk) disable iff (i_rst) // [RL7]
        (state_q == ddc_pkg::DDC_ST_WAIT_NVM && !i_nvm_load_done) |=> !o_device_disabled)
        else $error("disabled before memory load");
    chk_allow_gates_entry: assert property (@(posedge i_clk) disable iff (i_rst) // [RL3]
        (state_q == ddc_pkg::DDC_ST_ACTIVE && !allow_q) |=> !o_device_disabled)
        else $error("disabled without allow bit");
    chk_entry_on_request: assert property (@(posedge i_clk) disable iff (i_rst) // [RL1]
        (state_q == ddc_pkg::DDC_ST_ACTIVE && may_disable && !prst_release) |=> o_device_disabled)
        else $error("request not honoured");
    chk_disabled_outputs: assert property (@(posedge i_clk) disable iff (i_rst) // [RL4]
        o_device_disabled |-> (o_link_state == `DDC_LINK_L3 && o_phy_power_down && !o_output_buffers_oe))
        else $error("disabled outputs wrong");
    chk_stay_disabled: assert property (@(posedge i_clk) disable iff (i_rst) // [RL5]
        (o_device_disabled && req_on && !prst_release) |=> o_device_disabled)
        else $error("left disable mode early");
    chk_reset_reload: assert property (@(posedge i_clk) disable iff (i_rst) // [RL6]
        (o_device_disabled && prst_release) |=> (state_q == ddc_pkg::DDC_ST_WAIT_NVM))
        else $error("no reload after host reset");
    chk_sync_delay: assert property (@(posedge i_clk) disable iff (i_rst) // [RL12]
        $fell(sif.level) |-> $past(pin_level, 3) == `DDC_REQ_ASSERTED)
        else $error("request not synchronised");
    chk_release_exit: assert property (@(posedge i_clk) disable iff (i_rst) // [RL5]
        (o_device_disabled && !req_on) |=> !o_device_disabled)
        else $error("stuck disabled after release");
    chk_pullup_idle: assert property (@(posedge i_clk) disable iff (i_rst) // [RL2]
        (!i_disable_request_n_oe) [*4] |=> (sif.level == `DDC_REQ_IDLE))
        else $error("undriven pin not read idle");
    chk_sync_no_glitch: assert property (@(posedge i_clk) disable iff (i_rst) // [RL12]
        $changed(sif.level) |-> $past(pin_level, 3) == $past(pin_level, 4))
        else $error("synchroniser passed a glitch");
    chk_sync_rise_delay: assert property (@(posedge i_clk) disable iff (i_rst) // [RL12]
        $rose(sif.level) |-> $past(pin_level, 3) == `DDC_REQ_IDLE)
        else $error("release not synchronised");
    chk_host_sync_delay: assert property (@(posedge i_clk) disable iff (i_rst) // [RL6]
        $rose(hif.level) |-> $past(i_host_link_reset_n, 3))
        else $error("host release not synchronised");
    chk_host_sync_fall: assert property (@(posedge i_clk) disable iff (i_rst) // [RL5]
        $fell(hif.level) |-> !$past(i_host_link_reset_n, 3))
        else $error("host assert not synchronised");
    chk_host_release_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // [RL6]
        prst_release |=> !prst_release)
        else $error("host release longer than one cycle");
    chk_host_release_active: assert property (@(posedge i_clk) disable iff (i_rst) // [RL6]
        (state_q == ddc_pkg::DDC_ST_ACTIVE && prst_release) |=> (state_q == ddc_pkg::DDC_ST_WAIT_NVM))
        else $error("no reload after host reset in active");
    chk_host_assert_ignored: assert property (@(posedge i_clk) disable iff (i_rst) // [RL5]
        (o_device_disabled && req_on && !hif.level) |=> o_device_disabled)
        else $error("host reset ended disable mode");
    chk_wait_holds: assert property (@(posedge i_clk) disable iff (i_rst) // [RL7]
        (state_q == ddc_pkg::DDC_ST_WAIT_NVM && !i_nvm_load_done) |=> (state_q == ddc_pkg::DDC_ST_WAIT_NVM))
        else $error("left wait before memory load");
    chk_wait_exit_active: assert property (@(posedge i_clk) disable iff (i_rst) // [RL3]
        (state_q == ddc_pkg::DDC_ST_WAIT_NVM && i_nvm_load_done && !i_nvm_disable_allow)
        |=> (state_q == ddc_pkg::DDC_ST_ACTIVE))
        else $error("not active after load without allow");
    chk_wait_enter_disable: assert property (@(posedge i_clk) disable iff (i_rst) // [RL7]
        (state_q == ddc_pkg::DDC_ST_WAIT_NVM && i_nvm_load_done && i_nvm_disable_allow && req_on)
        |=> o_device_disabled)
        else $error("not disabled after load with request");
    chk_allow_latched: assert property (@(posedge i_clk) disable iff (i_rst) // [RL3]
        (state_q == ddc_pkg::DDC_ST_WAIT_NVM && i_nvm_load_done) |=> (allow_q == $past(i_nvm_disable_allow)))
        else $error("allow bit not latched at load");
    chk_entry_needs_pin: assert property (@(posedge i_clk) disable iff (i_rst) // [RL1]
        $rose(o_device_disabled) |-> $past(req_on))
        else $error("disabled without request");
    chk_entry_needs_allow: assert property (@(posedge i_clk) disable iff (i_rst) // [RL3]
        $rose(o_device_disabled) |-> allow_q)
        else $error("disabled with allow bit clear");
    chk_no_direct_active: assert property (@(posedge i_clk) disable iff (i_rst) // [RL6]
        o_device_disabled |=> (state_q != ddc_pkg::DDC_ST_ACTIVE))
        else $error("left disable mode without reload");
    chk_active_outputs: assert property (@(posedge i_clk) disable iff (i_rst) // [RL4]
        !o_device_disabled |-> (o_link_state == `DDC_LINK_L0 && !o_phy_power_down && o_output_buffers_oe))
        else $error("enabled outputs wrong");
    chk_core_reset_wait: assert property (@(posedge i_clk) disable iff (i_rst) // [RL7]
        o_core_reset == (state_q == ddc_pkg::DDC_ST_WAIT_NVM))
        else $error("core reset not matching wait state");
endmodule // ddc_device_disable

// >>> hw/ddc_defines.svh
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// Pin level meanings
`define DDC_REQ_ASSERTED 1'h0
`define DDC_REQ_IDLE 1'h1
// Reset value of the allow bit before memory is loaded
`define DDC_ALLOW_RESET 1'h0
// Link power states on the state output
`define DDC_LINK_L0 2'h0
`define DDC_LINK_L3 2'h3
// Synchroniser length
`define DDC_SYNC_STAGES 3
// Host reset synchroniser level during reset
`define DDC_HRST_RESET 1'h0
// Plain flag levels
`define DDC_FLAG_OFF 1'h0
`define DDC_FLAG_ON 1'h1

`endif

// >>> hw/ddc_pkg.sv
package ddc_pkg;
    typedef enum logic [1:0] {
        DDC_ST_WAIT_NVM,
        DDC_ST_ACTIVE,
        DDC_ST_DISABLED
    } ddc_state_t;
endpackage

// >>> hw/ddc_sync_if.sv
`timescale 1ns/1ps
interface ddc_sync_if;
    logic raw;
    logic level;
    modport src (output raw, input level);
    modport dst (input raw, output level);
endinterface

// >>> hw/ddc_pin_sync.sv
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_pin_sync #(
    parameter logic RST_LEVEL = `DDC_REQ_IDLE
) (
    input wire logic i_clk,
    input wire logic i_rst,
    ddc_sync_if.dst s
);
    logic [`DDC_SYNC_STAGES-1:0] stage_q;
    logic level_q;
    wire agree = stage_q[1] == stage_q[2];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stage_q <= {`DDC_SYNC_STAGES{RST_LEVEL}};
            level_q <= RST_LEVEL;
        end else begin
            stage_q <= {stage_q[1:0], s.raw};
            if (agree) begin
                level_q <= stage_q[2];
            end
        end
    end

    assign s.level = level_q;
endmodule // ddc_pin_sync

// >>> test/ddc_fw_model.sv
`timescale 1ns/1ps
module ddc_fw_model (
    input wire logic i_clk,
    input wire logic i_want_off,
    input wire logic i_drive,
    input wire logic i_host_reset,
    output logic o_disable_request_n,
    output logic o_disable_request_n_oe,
    output logic o_host_link_reset_n
);
    logic gpio_q = 1'h1; // Enable level at power-up
    logic hrst_q = 1'h1;
    always_ff @(posedge i_clk) begin
        gpio_q <= ~i_want_off; // Held through host reset
        hrst_q <= ~i_host_reset;
    end
    assign o_host_link_reset_n = hrst_q;
    assign o_disable_request_n_oe = i_drive;
    assign o_disable_request_n = i_drive ? gpio_q : 1'h0; // Floating wire; only the device pull-up reads idle
endmodule // ddc_fw_model

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "ddc_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic off = 1'h0;
    logic drv = 1'h1;
    logic hrst = 1'h0;
    logic load = 1'h0;
    logic allow = 1'h0;
    logic req_n, req_oe, hrst_n, dis, ppd, boe, crst;
    logic [1:0] link;
    int error_cnt = 0;
    int n_checks = 0;
    always #4 i_clk = ~i_clk;
    ddc_fw_model ddc_fw_model_inst (.i_clk(i_clk), .i_want_off(off), .i_drive(drv), .i_host_reset(hrst),
        .o_disable_request_n(req_n), .o_disable_request_n_oe(req_oe), .o_host_link_reset_n(hrst_n));
    ddc_device_disable ddc_device_disable_inst (.i_clk(i_clk), .i_rst(i_rst), .i_disable_request_n(req_n),
        .i_disable_request_n_oe(req_oe), .i_host_link_reset_n(hrst_n), .i_nvm_load_done(load),
        .i_nvm_disable_allow(allow), .o_device_disabled(dis), .o_link_state(link),
        .o_phy_power_down(ppd), .o_output_buffers_oe(boe), .o_core_reset(crst));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic chk(input logic d, input logic cr);
        @(negedge i_clk);
        `CHK("disabled", d, dis)
        `CHK("link", d ? `DDC_LINK_L3 : `DDC_LINK_L0, link)
        `CHK("phy_pd", d, ppd)
        `CHK("buf_oe", ~d, boe)
        `CHK("core_rst", cr, crst)
        @(posedge i_clk);
    endtask
    task automatic t_powerup;
        off <= 1'h1;
        cyc(10);
        chk(1'h0, 1'h1);
        allow <= 1'h1;
        load <= 1'h1;
        cyc(8);
        chk(1'h1, 1'h0);
        $display("powerup done");
    endtask
    task automatic t_disable;
        off <= 1'h0;
        cyc(12);
        chk(1'h0, 1'h0);
        off <= 1'h1;
        cyc(2);
        chk(1'h0, 1'h0);
        cyc(8);
        chk(1'h1, 1'h0);
        cyc(4);
        chk(1'h1, 1'h0); // Four cycles later, device stays off
        $display("disable done");
    endtask
    task automatic t_host;
        hrst <= 1'h1;
        cyc(8);
        chk(1'h1, 1'h0);
        hrst <= 1'h0;
        load <= 1'h0;
        cyc(12);
        chk(1'h0, 1'h1);
        load <= 1'h1;
        cyc(2);
        chk(1'h1, 1'h0);
        $display("host reset done");
    endtask
    task automatic t_refuse;
        off <= 1'h0;
        allow <= 1'h0;
        cyc(12);
        off <= 1'h1;
        cyc(12);
        chk(1'h0, 1'h0);
        $display("refuse done");
    endtask
    task automatic t_pullup;
        drv <= 1'h0;
        allow <= 1'h1;
        hrst <= 1'h1;
        cyc(4);
        hrst <= 1'h0;
        cyc(12);
        chk(1'h0, 1'h0);
        drv <= 1'h1;
        cyc(12);
        chk(1'h1, 1'h0);
        $display("pullup done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        cyc(2);
        i_rst <= 1'h0;
        t_powerup();
        t_disable();
        t_host();
        t_refuse();
        t_pullup();
        report_and_stop();
    end
endmodule // testbench
